/* core/tmr_pkg.sv */
// Purpose: Shared constants and state types of the timer 2 capture/reload counter.
// Assumes: Byte-wide register port with 8-bit addresses.
// Notes:   Every offset, bit position and divide ratio lives here; the dividers and fall detectors set their own reset values.
package tmr_pkg;
   localparam int        ADDR_W     = 8;
   localparam int        DATA_W     = 8;
   localparam logic [7:0] OFS_CTRL  = 8'hC8;
   localparam logic [7:0] OFS_MODE  = 8'hC9;
   localparam logic [7:0] OFS_CAPL  = 8'hCA;
   localparam logic [7:0] OFS_CAPH  = 8'hCB;
   localparam logic [7:0] OFS_CNTL  = 8'hCC;
   localparam logic [7:0] OFS_CNTH  = 8'hCD;
   localparam logic [7:0] OFS_CLOCK_CONTROL_REG = 8'h8E;
   localparam logic [7:0] OFS_ISTAT = 8'hD0;
   localparam logic [7:0] OFS_IMASK = 8'hD1;
   localparam int CTRL_OVF   = 7;
   localparam int CTRL_EXT   = 6;
   localparam int CTRL_RCLK  = 5;
   localparam int CTRL_TX_BAUD_CLOCK_BIT  = 4;
   localparam int CTRL_EXEN  = 3;
   localparam int CTRL_RUN   = 2;
   localparam int CTRL_CT    = 1;
   localparam int CTRL_CPRL  = 0;
   localparam int MODE_FIRST_TIMER_DIV13_BIT = 4;
   localparam int MODE_SECOND_TIMER_DIV13_BIT = 3;
   localparam int MODE_OE    = 1;
   localparam int MODE_DOWN_COUNT_ENABLE  = 0;
   localparam int CK_T2M     = 5;
   localparam int CK_T1M     = 4;
   localparam int IRQ_OVF    = 0;
   localparam int IRQ_EXT    = 1;
   localparam logic [7:0]  MODE_MASK  = 8'h1B;
   localparam logic [7:0]  CLOCK_CONTROL_REG_MASK = 8'h30;
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [15:0] RST_WORD   = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;
   localparam logic [15:0] CNT_ONE    = 16'h0001;
   localparam int DIV_SLOW = 12;
   localparam int DIV_FAST = 4;
   localparam int DIV_13   = 13;
   localparam int DIV_BAUD = 2;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  mode;
      logic [7:0]  clock_control_reg;
      logic [15:0] cap;
      logic [15:0] cnt;
      logic [1:0]  istat;
      logic [1:0]  imask;
      logic        pin_clk;
      logic [7:0]  rdata;
   } tmr_state_t;
endpackage

/* core/tmr_tick_if.sv */
// Purpose: Carries one prescaler tick from a divider into the counter core.
// Assumes: Tick is a single-cycle pulse on clk_sys.
// Notes:   One instance per divider.
`timescale 1ns/10ps
`default_nettype none
interface tmr_tick_if;
   logic tick;
   modport src (output tick);
   modport snk (input tick);
endinterface
`default_nettype wire

/* core/tmr_divider.sv */
// Purpose: Free-running divider that pulses its tick once every DIV clocks.
// Assumes: DIV is at least 2.
// Notes:   The tick comes from a flip-flop.
`timescale 1ns/10ps
`default_nettype none
module tmr_divider #(
   parameter int DIV = 12
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   tmr_tick_if.src   tick_out
);
   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   localparam logic [W-1:0] ZERO = '0;
   localparam logic [W-1:0] ONE  = W'(1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } tmr_div_state_t;

   tmr_div_state_t s;
   tmr_div_state_t next_s;

   always_comb begin
      next_s      = s;
      next_s.tick = (s.cnt == LAST);
      next_s.cnt  = (s.cnt == LAST) ? ZERO : s.cnt + ONE;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick_out.tick = s.tick;
endmodule
`default_nettype wire

/* core/tmr_fall_detect.sv */
// Purpose: Flags a falling transition on a pin that is synchronous to clk_sys.
// Assumes: The pin idles high.
// Notes:   The flag is high in the cycle the pin is first seen low.
`timescale 1ns/10ps
`default_nettype none
module tmr_fall_detect (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      fall
);
   typedef struct packed {
      logic prev;
   } tmr_fall_state_t;

   tmr_fall_state_t s;
   tmr_fall_state_t next_s;

   always_comb begin
      next_s      = s;
      next_s.prev = pin;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s <= '1;
      end else begin
         s <= next_s;
      end
   end

   assign fall = s.prev & ~pin;
endmodule
`default_nettype wire

/* core/tmr_timer2.sv */
// Purpose: Timer 2 capture/autoreload counter with clock output and timer 1 clock select.
// Assumes: Oscillator and system clock are both clk_sys; pins are synchronous to it.
// Notes:   Registers sit behind a byte port with read data one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module tmr_timer2 (
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       count_input_pin,
   output logic            count_pin_out,
   output logic            count_pin_oe,
   input  wire logic       trigger_input_pin,
   input  wire logic       timer1_pin,
   input  wire logic       timer1_counter_select,
   output logic            timer1_tick,
   output logic            irq
);
   logic [1:0]           rst_sync;
   logic                 rst_n;
   tmr_pkg::tmr_state_t  s;
   tmr_pkg::tmr_state_t  next_s;
   logic                 cnt_fall;
   logic                 trig_fall;
   logic                 t1_fall;
   logic                 baud;
   logic                 clkout;
   logic                 capture_mode;
   logic                 down;
   logic                 tick;
   logic                 step;
   logic                 trig_evt;
   logic                 ovf_evt;
   logic                 ext_evt;
   logic                 ovf_set;
   logic                 wr_ctrl;
   logic                 wr_cnt;

   tmr_tick_if tick12_if ();
   tmr_tick_if tick4_if ();
   tmr_tick_if tick2_if ();
   tmr_tick_if tick13a_if ();
   tmr_tick_if tick13b_if ();

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   tmr_divider #(.DIV(tmr_pkg::DIV_SLOW)) u_div12 (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .tick_out (tick12_if.src)
   );
   tmr_divider #(.DIV(tmr_pkg::DIV_FAST)) u_div4 (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .tick_out (tick4_if.src)
   );
   tmr_divider #(.DIV(tmr_pkg::DIV_BAUD)) u_div2 (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .tick_out (tick2_if.src)
   );
   // Timer 1 and timer 2 each own a divide-by-13 so neither phase disturbs the other.
   tmr_divider #(.DIV(tmr_pkg::DIV_13)) u_div13_t1 (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .tick_out (tick13a_if.src)
   );
   tmr_divider #(.DIV(tmr_pkg::DIV_13)) u_div13_t2 (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .tick_out (tick13b_if.src)
   );

   tmr_fall_detect u_cnt_fall (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin     (count_input_pin),
      .fall    (cnt_fall)
   );
   tmr_fall_detect u_trig_fall (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin     (trigger_input_pin),
      .fall    (trig_fall)
   );
   tmr_fall_detect u_t1_fall (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin     (timer1_pin),
      .fall    (t1_fall)
   );

   always_comb begin
      next_s       = s;
      next_s.rdata = tmr_pkg::RST_BYTE;
      baud         = s.ctrl[tmr_pkg::CTRL_RCLK] | s.ctrl[tmr_pkg::CTRL_TX_BAUD_CLOCK_BIT];
      clkout       = s.mode[tmr_pkg::MODE_OE] & ~s.ctrl[tmr_pkg::CTRL_CT];
      capture_mode = s.ctrl[tmr_pkg::CTRL_CPRL] & ~baud & ~clkout;
      down         = ~capture_mode & ~baud & ~clkout & s.mode[tmr_pkg::MODE_DOWN_COUNT_ENABLE]
                     & ~trigger_input_pin;
      if (baud | clkout) begin
         tick = tick2_if.tick;
      end else if (s.ctrl[tmr_pkg::CTRL_CT]) begin
         tick = s.mode[tmr_pkg::MODE_SECOND_TIMER_DIV13_BIT] ? tick13b_if.tick : cnt_fall;
      end else begin
         tick = s.clock_control_reg[tmr_pkg::CK_T2M] ? tick4_if.tick : tick12_if.tick;
      end
      step     = s.ctrl[tmr_pkg::CTRL_RUN] & tick;
      trig_evt = s.ctrl[tmr_pkg::CTRL_EXEN] & trig_fall;
      ovf_evt  = 1'b0;
      ext_evt  = 1'b0;

      if (step) begin
         if (down) begin
            if (s.cnt == s.cap) begin
               next_s.cnt = tmr_pkg::CNT_MAX;
               ovf_evt    = 1'b1;
            end else begin
               next_s.cnt = s.cnt - tmr_pkg::CNT_ONE;
            end
         end else if (s.cnt == tmr_pkg::CNT_MAX) begin
            ovf_evt    = 1'b1;
            // Capture mode wraps to zero; every other mode reloads the whole word.
            next_s.cnt = capture_mode ? tmr_pkg::RST_WORD : s.cap;
         end else begin
            next_s.cnt = s.cnt + tmr_pkg::CNT_ONE;
         end
      end

      if (ovf_evt & clkout) begin
         next_s.pin_clk = ~s.pin_clk;
      end

      if (trig_evt) begin
         if (capture_mode) begin
            next_s.cap = s.cnt;
            ext_evt    = 1'b1;
         end else if (~s.mode[tmr_pkg::MODE_DOWN_COUNT_ENABLE]) begin
            ext_evt = 1'b1;
            if (~baud & ~clkout) begin
               next_s.cnt = s.cap;
            end
         end
      end

      // Rollovers in baud or clock-output use never flag an overflow.
      ovf_set = ovf_evt & ~baud & ~clkout;
      wr_ctrl = reg_wr & (reg_addr == tmr_pkg::OFS_CTRL);
      wr_cnt  = reg_wr & ((reg_addr == tmr_pkg::OFS_CNTL) | (reg_addr == tmr_pkg::OFS_CNTH));

      if (reg_wr) begin
         unique case (reg_addr)
            tmr_pkg::OFS_CTRL:  next_s.ctrl = reg_wdata;
            tmr_pkg::OFS_MODE:  next_s.mode = reg_wdata & tmr_pkg::MODE_MASK;
            tmr_pkg::OFS_CLOCK_CONTROL_REG: next_s.clock_control_reg = reg_wdata & tmr_pkg::CLOCK_CONTROL_REG_MASK;
            tmr_pkg::OFS_CAPL:  next_s.cap[7:0] = reg_wdata;
            tmr_pkg::OFS_CAPH:  next_s.cap[15:8] = reg_wdata;
            tmr_pkg::OFS_CNTL:  next_s.cnt[7:0] = reg_wdata;
            tmr_pkg::OFS_CNTH:  next_s.cnt[15:8] = reg_wdata;
            tmr_pkg::OFS_IMASK: next_s.imask = reg_wdata[1:0];
            default: begin
            end
         endcase
      end

      // Hardware events win over a clearing write in the same cycle.
      next_s.ctrl[tmr_pkg::CTRL_OVF] = next_s.ctrl[tmr_pkg::CTRL_OVF] | ovf_set;
      next_s.ctrl[tmr_pkg::CTRL_EXT] = next_s.ctrl[tmr_pkg::CTRL_EXT] | ext_evt;
      if (reg_wr && reg_addr == tmr_pkg::OFS_ISTAT) begin
         next_s.istat = s.istat & ~reg_wdata[1:0];
      end
      next_s.istat[tmr_pkg::IRQ_OVF] = next_s.istat[tmr_pkg::IRQ_OVF] | ovf_set;
      next_s.istat[tmr_pkg::IRQ_EXT] = next_s.istat[tmr_pkg::IRQ_EXT] | ext_evt;

      if (reg_rd) begin
         unique case (reg_addr)
            tmr_pkg::OFS_CTRL:  next_s.rdata = s.ctrl;
            tmr_pkg::OFS_MODE:  next_s.rdata = s.mode;
            tmr_pkg::OFS_CLOCK_CONTROL_REG: next_s.rdata = s.clock_control_reg;
            tmr_pkg::OFS_CAPL:  next_s.rdata = s.cap[7:0];
            tmr_pkg::OFS_CAPH:  next_s.rdata = s.cap[15:8];
            tmr_pkg::OFS_CNTL:  next_s.rdata = s.cnt[7:0];
            tmr_pkg::OFS_CNTH:  next_s.rdata = s.cnt[15:8];
            tmr_pkg::OFS_ISTAT: next_s.rdata = {6'h00, s.istat};
            tmr_pkg::OFS_IMASK: next_s.rdata = {6'h00, s.imask};
            default:            next_s.rdata = tmr_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   always_comb begin
      if (timer1_counter_select) begin
         timer1_tick = s.mode[tmr_pkg::MODE_FIRST_TIMER_DIV13_BIT] ? tick13a_if.tick : t1_fall;
      end else begin
         timer1_tick = s.clock_control_reg[tmr_pkg::CK_T1M] ? tick4_if.tick : tick12_if.tick;
      end
   end

   assign reg_rdata     = s.rdata;
   assign count_pin_out = s.pin_clk;
   assign count_pin_oe  = clkout;
   assign irq           = |(s.istat & s.imask);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_gap12;
      (!tick12_if.tick)[*8] ##1 (!tick12_if.tick)[*3] ##1 tick12_if.tick;
   endsequence
   sequence s_gap13;
      (!tick13b_if.tick)[*8] ##1 (!tick13b_if.tick)[*4] ##1 tick13b_if.tick;
   endsequence
   sequence s_quiet_up;
      step && !down && !reg_wr && !trig_evt;
   endsequence

   a_run_hold: assert property (!s.ctrl[tmr_pkg::CTRL_RUN] && !wr_cnt && !trig_evt
      |=> s.cnt == $past(s.cnt)) else $error("count moved while stopped");
   a_pin_count: assert property (s_quiet_up and s.ctrl[tmr_pkg::CTRL_CT]
      && !s.mode[tmr_pkg::MODE_SECOND_TIMER_DIV13_BIT] && !baud && !clkout && s.cnt != tmr_pkg::CNT_MAX
      |-> cnt_fall ##1 s.cnt == $past(s.cnt) + tmr_pkg::CNT_ONE)
      else $error("pin edge did not count");
   a_speed_sel: assert property (!s.ctrl[tmr_pkg::CTRL_CT] && !baud && !clkout
      |-> tick == (s.clock_control_reg[tmr_pkg::CK_T2M] ? tick4_if.tick : tick12_if.tick))
      else $error("wrong timer rate");
   a_baud_div2: assert property ((baud || clkout) |-> tick == tick2_if.tick
      and (tick2_if.tick |=> !tick2_if.tick ##1 tick2_if.tick))
      else $error("baud clock not half rate");
   a_capture_copy: assert property (trig_evt && capture_mode && !reg_wr
      |=> s.cap == $past(s.cnt) && s.ctrl[tmr_pkg::CTRL_EXT])
      else $error("capture missed");
   a_div12_gap: assert property (tick12_if.tick |=> s_gap12)
      else $error("divide-by-12 spacing wrong");
   a_div13_sel: assert property (s.ctrl[tmr_pkg::CTRL_CT] && s.mode[tmr_pkg::MODE_SECOND_TIMER_DIV13_BIT]
      && !baud && !clkout |-> tick == tick13b_if.tick and (tick13b_if.tick |=> s_gap13))
      else $error("divide-by-13 source wrong");
   a_t1_select: assert property (timer1_counter_select && s.mode[tmr_pkg::MODE_FIRST_TIMER_DIV13_BIT]
      |-> timer1_tick == tick13a_if.tick) else $error("timer 1 source wrong");
   a_clkout_quiet: assert property (clkout && step && s.cnt == tmr_pkg::CNT_MAX
      && !s.ctrl[tmr_pkg::CTRL_OVF] && !reg_wr
      |=> !s.ctrl[tmr_pkg::CTRL_OVF] && count_pin_out != $past(count_pin_out))
      else $error("clock output rollover misbehaved");
   a_pin_input: assert property (!s.mode[tmr_pkg::MODE_OE] |-> !count_pin_oe)
      else $error("count pin driven while disabled");
   a_down_step: assert property (step && down && s.cnt != s.cap && !reg_wr && !trig_evt
      |=> s.cnt == $past(s.cnt) - tmr_pkg::CNT_ONE) else $error("down count wrong");
   a_capl_read: assert property (reg_rd && reg_addr == tmr_pkg::OFS_CAPL
      |=> reg_rdata == $past(s.cap[7:0])) else $error("capture low readback wrong");
   a_ovf_flag: assert property (s_quiet_up and s.cnt == tmr_pkg::CNT_MAX && !baud && !clkout
      |=> s.ctrl[tmr_pkg::CTRL_OVF] && s.istat[tmr_pkg::IRQ_OVF])
      else $error("overflow flag not set");
   a_reload_word: assert property (s_quiet_up and !capture_mode && s.cnt == tmr_pkg::CNT_MAX
      |=> s.cnt == $past(s.cap)) else $error("autoreload word wrong");
endmodule
`default_nettype wire

/* bench/tmr_pin_model.sv */
// Purpose: Drives the external count, trigger and timer 1 pins of the timer 2 block.
// Assumes: The pins are synchronous to clk_sys and idle high as pulled-up port pins.
// Notes:   Every pin changes only just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module tmr_pin_model (
   input  wire logic clk_sys,
   output logic      count_drv,
   output logic      trigger_input_pin,
   output logic      timer1_pin
);
   initial begin
      count_drv         = 1'b1;
      trigger_input_pin = 1'b1;
      timer1_pin        = 1'b1;
   end

   // Each fall is one cycle low after at least one cycle high.
   task automatic fall_count(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         count_drv <= 1'b0;
         @(posedge clk_sys);
         count_drv <= 1'b1;
      end
      @(posedge clk_sys);
   endtask

   task automatic fall_t1(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         timer1_pin <= 1'b0;
         @(posedge clk_sys);
         timer1_pin <= 1'b1;
      end
      @(posedge clk_sys);
   endtask

   task automatic set_trig(input logic lvl);
      @(posedge clk_sys);
      trigger_input_pin <= lvl;
      @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Purpose: Self-checking bench for the timer 2 capture/reload counter.
// Assumes: Register port with read data in the cycle after the read strobe.
// Notes:   Rates are checked within one tick, since the dividers free-run.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk_sys, rstn, reg_wr, reg_rd, t1_sel, last_out;
   logic [7:0]  reg_addr, reg_wdata;
   logic [15:0] v, w;
   wire logic [7:0] reg_rdata;
   wire logic   count_pin_out, count_pin_oe, count_pin, count_drv, trig_pin, t1_pin;
   wire logic   timer1_tick, irq;
   int          n_fail = 0, samples_checked = 0, cycles = 0, t1_ticks = 0, toggles = 0, s;

   // The count pin carries the block's clock while it drives, else the model's level.
   assign count_pin = count_pin_oe ? count_pin_out : count_drv;

   tmr_timer2 dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .count_input_pin(count_pin), .count_pin_out(count_pin_out),
      .count_pin_oe(count_pin_oe), .trigger_input_pin(trig_pin), .timer1_pin(t1_pin),
      .timer1_counter_select(t1_sel), .timer1_tick(timer1_tick), .irq(irq));
   tmr_pin_model pm (.clk_sys(clk_sys), .count_drv(count_drv),
      .trigger_input_pin(trig_pin), .timer1_pin(t1_pin));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles   <= cycles + 1;
      t1_ticks <= t1_ticks + int'(timer1_tick);
      last_out <= count_pin_out;
      toggles  <= toggles + int'(count_pin_out !== last_out);
      if (cycles == 10000) begin
         n_fail++;
         conclude();
      end
   end

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         n_fail++;
      end
   endtask

   task automatic rng(input string n, input int lo, input int hi, input int g);
      samples_checked++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         $display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi, g);
         n_fail++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk_sys);
   endtask

   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a, d[7:0]);
      wr(a + 8'h01, d[15:8]);
   endtask

   task automatic rd16(input logic [7:0] a, output logic [15:0] d);
      rd(a, d[7:0]);
      rd(a + 8'h01, d[15:8]);
   endtask

   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] g;
      rd(a, g);
      chk(n, {8'h00, e}, {8'h00, g});
   endtask

   // Runs the timer for n+2 edges from a zero count, then reads the count.
   task automatic run_for(input logic [7:0] c, input int n, output logic [15:0] d);
      wr16(8'hCC, 16'h0000);
      wr(8'hC8, c);
      repeat (n) @(posedge clk_sys);
      wr(8'hC8, c & 8'hFB);
      rd16(8'hCC, d);
   endtask

   initial begin
      {reg_wr, reg_rd, t1_sel} = 3'b000;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      rstn      = 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rchk("cap low reset", 8'hCA, 8'h00);
      wr(8'hCA, 8'hA5);
      rchk("cap low rw", 8'hCA, 8'hA5);
      rchk("unmapped", 8'h00, 8'h00);
      $display("registers done");
      wr(8'h8E, 8'h20);
      run_for(8'h04, 39, v);
      rng("fast timer", 9, 11, int'(v));
      wr(8'h8E, 8'h00);
      run_for(8'h04, 119, v);
      rng("slow timer", 9, 11, int'(v));
      repeat (30) @(posedge clk_sys);
      rd16(8'hCC, w);
      chk("held count", v, w);
      run_for(8'h14, 39, v);
      rng("baud half rate", 19, 21, int'(v));
      wr(8'hC9, 8'h08);
      run_for(8'h06, 129, v);
      rng("div13 timer", 9, 11, int'(v));
      wr(8'hC9, 8'h00);
      wr16(8'hCC, 16'h0000);
      wr(8'hC8, 8'h06);
      pm.fall_count(5);
      rd16(8'hCC, v);
      chk("pin count", 16'h0005, v);
      chk("pin released", 16'h0000, {15'h0, count_pin_oe});
      $display("clock sources done");
      wr(8'hD1, 8'h03);
      wr16(8'hCA, 16'hFFF0);
      wr16(8'hCC, 16'hFFFE);
      pm.fall_count(2);
      rd16(8'hCC, v);
      chk("reload word", 16'hFFF0, v);
      rchk("overflow flag", 8'hC8, 8'h86);
      chk("irq raised", 16'h0001, {15'h0, irq});
      wr(8'hD0, 8'h01);
      chk("irq cleared", 16'h0000, {15'h0, irq});
      wr(8'hC8, 8'h02);
      wr(8'hD1, 8'h00);
      wr(8'hC9, 8'h01);
      wr16(8'hCC, 16'hFFF1);
      wr(8'hC8, 8'h06);
      pm.fall_count(1);
      rd16(8'hCC, v);
      chk("down_count_enable up", 16'hFFF2, v);
      pm.set_trig(1'b0);
      pm.fall_count(2);
      rd16(8'hCC, v);
      chk("down count", 16'hFFF0, v);
      pm.fall_count(1);
      rd16(8'hCC, v);
      chk("underflow", 16'hFFFF, v);
      rchk("down flag", 8'hC8, 8'h86);
      $display("autoreload done");
      wr(8'hC8, 8'h00);
      wr(8'hC9, 8'h00);
      pm.set_trig(1'b1);
      wr16(8'hCC, 16'h1234);
      wr16(8'hCA, 16'h0000);
      wr(8'hD0, 8'hFF);
      wr(8'hC8, 8'h09);
      pm.set_trig(1'b0);
      rd16(8'hCA, v);
      chk("capture word", 16'h1234, v);
      rchk("ext status", 8'hD0, 8'h02);
      pm.set_trig(1'b1);
      $display("capture done");
      wr(8'hC8, 8'h00);
      wr(8'hC9, 8'h02);
      chk("pin driven", 16'h0001, {15'h0, count_pin_oe});
      wr16(8'hCA, 16'hFFFC);
      wr16(8'hCC, 16'hFFFC);
      wr(8'hD0, 8'hFF);
      wr(8'hD1, 8'h03);
      s = toggles;
      wr(8'hC8, 8'h04);
      repeat (79) @(posedge clk_sys);
      wr(8'hC8, 8'h00);
      rng("clock out toggles", 9, 11, toggles - s);
      rchk("no overflow", 8'hC8, 8'h00);
      chk("no irq", 16'h0000, {15'h0, irq});
      wr(8'hC9, 8'h10);
      t1_sel <= 1'b1;
      @(posedge clk_sys);
      s = t1_ticks;
      repeat (130) @(posedge clk_sys);
      rng("t1 div13", 9, 11, t1_ticks - s);
      wr(8'hC9, 8'h00);
      s = t1_ticks;
      pm.fall_t1(3);
      @(posedge clk_sys);
      chk("t1 pin", 16'h0003, 16'(t1_ticks - s));
      t1_sel <= 1'b0;
      wr(8'h8E, 8'h10);
      s = t1_ticks;
      repeat (40) @(posedge clk_sys);
      rng("t1 fast", 9, 11, t1_ticks - s);
      $display("clock output and timer 1 done");
      conclude();
   end
endmodule
`default_nettype wire
